// [wdsp_regs.svh]
`ifndef WDSP_REGS_SVH
`define WDSP_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define WDSP_OFF_REFRESH 12'h000
`define WDSP_OFF_START 12'h004
`define WDSP_OFF_CTRL 12'h008
`define WDSP_OFF_STAT 12'h010
`define WDSP_OFF_MASK 12'h014
`define WDSP_OFF_PMC 12'h01C
// ****************************************
// fields and reset values
// ****************************************
`define WDSP_CTRL_PRE_BIT 7
`define WDSP_PMC_RST 8'h00
`define WDSP_PMC_RST_PROT 8'h80
`define WDSP_REFRESH_FIRST 8'h00
`define WDSP_REFRESH_SECOND 8'hFF
// ****************************************
// counts
// ****************************************
`define WDSP_INIT_FULL 15'h7FFF
`define WDSP_INIT_SEL0 15'h01FF
`define WDSP_INIT_SEL1 15'h03FF
`define WDSP_INIT_SEL2 15'h07FF
`define WDSP_INIT_SEL3 15'h0FFF
`define WDSP_PRE_LAST0 7'h0F
`define WDSP_PRE_LAST1 7'h7F
`define WDSP_SUB_LAST 5'h1F
`endif

// [wdsp_pkg.sv]
package wdsp_pkg;
    typedef struct packed {
        logic prot;
        logic [3:0] unused;
        logic src_sel;
        logic [1:0] cvs;
    } wdsp_pmc_type;
    typedef enum logic [0:0] {WDSP_IDLE, WDSP_ARMED} wdsp_seq_type;
endpackage

// [wdsp_top.sv]
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "wdsp_regs.svh"
//Contract
// - 15-bit counter decrements once per count-source tick while running.
// - unprotected source is cpu clock or subclock/32; protected uses low-speed oscillator.
// - auto start option comes from flash option bit sampled at reset.
// - cpu source halts in stop/wait, subclock only in stop, protected never.
// - writing 00h then FFh to refresh restarts; only that, reset, a start register write, underflow reload.
// - underflow raises interrupt or reset; protected always raises reset.
// - cpu clock source goes through prescaler chosen by prescaler select bit.
// - with subclock, initial count field picks 01FFh, 03FFh, 07FFh or 0FFFh.
// - flash bit selects protection after reset; otherwise software sets it.
// - source select bit 0 picks cpu clock, 1 picks subclock divided by 32.
// - protect enable bit 0 disables, 1 enables protection mode.
// - bits 6..3 of protection register read 0; software writes 0.
// - protect bit needs a 0 write before 1; once set, 0 cannot clear.
// - source select acts only while protection is off.
// - initial count field acts only while source select is 1.
// - flash-enabled protection makes protection register reset to 80h.
module wdsp_top
    import wdsp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic subclock_input,
    input wire logic lso_clk_in,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic underflow_reset_sel,
    input wire logic auto_start_select,
    input wire logic protect_after_reset_bit,
    output logic irq,
    output logic wdt_reset
);
    // ****************************************
    // apb slave
    // ****************************************
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic acc, wr, mapped;
    logic [31:0] rd_d;
    wdsp_pmc_type pmc_q;
    logic [7:0] ctrl_q;
    logic [0:0] stat_q, mask_q;
    logic [14:0] cnt_q;
    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;
    always_comb begin
        mapped = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            `WDSP_OFF_REFRESH: rd_d = 32'h0000_0000;
            `WDSP_OFF_START: rd_d = {17'h00000, cnt_q};
            `WDSP_OFF_CTRL: rd_d = {24'h000000, ctrl_q};
            `WDSP_OFF_STAT: rd_d = {31'h00000000, stat_q};
            `WDSP_OFF_MASK: rd_d = {31'h00000000, mask_q};
            `WDSP_OFF_PMC: rd_d = {24'h000000, pmc_q.prot, 4'h0, pmc_q.src_sel, pmc_q.cvs};
            default: mapped = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    // ****************************************
    // option capture after reset release
    // ****************************************
    logic strap_done_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
        end
    end
    // ****************************************
    // registers
    // ****************************************
    logic prot_armed_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pmc_q <= `WDSP_PMC_RST;
            prot_armed_q <= 1'b0;
            ctrl_q <= 8'h00;
            mask_q <= 1'b0;
        end else begin
            if (!strap_done_q && !protect_after_reset_bit) begin
                pmc_q <= `WDSP_PMC_RST_PROT;
            end else if (wr && paddr == `WDSP_OFF_PMC) begin
                pmc_q.cvs <= pwdata[1:0];
                if (!pmc_q.prot) begin
                    pmc_q.src_sel <= pwdata[2];
                end
                if (pwdata[7] && prot_armed_q) begin
                    pmc_q.prot <= 1'b1;
                end
                prot_armed_q <= !pwdata[7];
            end
            if (wr && paddr == `WDSP_OFF_CTRL) begin
                ctrl_q <= {pwdata[7], 7'h00};
            end
            if (wr && paddr == `WDSP_OFF_MASK) begin
                mask_q <= pwdata[0];
            end
        end
    end
    // ****************************************
    // count sources
    // ****************************************
    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic lso_s1_q, lso_s2_q, lso_s3_q;
    logic [4:0] sub_div_q;
    logic [6:0] pre_q;
    logic sub_tick, lso_tick, cpu_tick, tick, use_sub;
    logic [6:0] pre_last;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
            lso_s1_q <= 1'b0;
            lso_s2_q <= 1'b0;
            lso_s3_q <= 1'b0;
        end else begin
            sub_s1_q <= subclock_input;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            lso_s1_q <= lso_clk_in;
            lso_s2_q <= lso_s1_q;
            lso_s3_q <= lso_s2_q;
        end
    end
    assign pre_last = ctrl_q[`WDSP_CTRL_PRE_BIT] ? `WDSP_PRE_LAST1 : `WDSP_PRE_LAST0;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_div_q <= 5'h00;
            pre_q <= 7'h00;
        end else begin
            if (sub_s2_q && !sub_s3_q) begin
                sub_div_q <= sub_div_q + 5'h01;
            end
            pre_q <= (pre_q >= pre_last) ? 7'h00 : pre_q + 7'h01;
        end
    end
    assign sub_tick = sub_s2_q && !sub_s3_q && sub_div_q == `WDSP_SUB_LAST;
    assign lso_tick = lso_s2_q && !lso_s3_q;
    assign cpu_tick = pre_q >= pre_last;
    assign use_sub = pmc_q.src_sel && !pmc_q.prot;
    always_comb begin
        if (pmc_q.prot) begin
            tick = lso_tick;
        end else if (use_sub) begin
            tick = sub_tick && !stop_mode;
        end else begin
            tick = cpu_tick && !stop_mode && !wait_mode;
        end
    end
    // ****************************************
    // counter
    // ****************************************
    logic [14:0] init_val;
    logic running_q, start_wr, refresh, uflow;
    wdsp_seq_type seq_q;
    always_comb begin
        init_val = `WDSP_INIT_FULL;
        if (use_sub) begin
            case (pmc_q.cvs)
                2'h0: init_val = `WDSP_INIT_SEL0;
                2'h1: init_val = `WDSP_INIT_SEL1;
                2'h2: init_val = `WDSP_INIT_SEL2;
                default: init_val = `WDSP_INIT_SEL3;
            endcase
        end
    end
    assign start_wr = wr && paddr == `WDSP_OFF_START;
    assign refresh = wr && paddr == `WDSP_OFF_REFRESH && seq_q == WDSP_ARMED
        && pwdata[7:0] == `WDSP_REFRESH_SECOND;
    assign uflow = running_q && tick && cnt_q == 15'h0000;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_q <= WDSP_IDLE;
        end else if (wr && paddr == `WDSP_OFF_REFRESH) begin
            case (seq_q)
                WDSP_IDLE: seq_q <= (pwdata[7:0] == `WDSP_REFRESH_FIRST) ? WDSP_ARMED : WDSP_IDLE;
                WDSP_ARMED: seq_q <= (pwdata[7:0] == `WDSP_REFRESH_FIRST) ? WDSP_ARMED : WDSP_IDLE;
                default: seq_q <= WDSP_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            running_q <= 1'b0;
            cnt_q <= `WDSP_INIT_FULL;
        end else begin
            if ((!strap_done_q && !auto_start_select) || start_wr) begin
                running_q <= 1'b1;
            end
            if (!strap_done_q || start_wr || refresh || uflow) begin
                cnt_q <= init_val;
            end else if (running_q && tick) begin
                cnt_q <= cnt_q - 15'h0001;
            end
        end
    end
    // ****************************************
    // underflow action and interrupt
    // ****************************************
    logic uf_irq, uf_rst;
    assign uf_rst = uflow && (pmc_q.prot || underflow_reset_sel);
    assign uf_irq = uflow && !pmc_q.prot && !underflow_reset_sel;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= 1'b0;
            irq <= 1'b0;
            wdt_reset <= 1'b0;
        end else begin
            if (uf_irq) begin
                stat_q <= 1'b1;
            end else if (wr && paddr == `WDSP_OFF_STAT && pwdata[0]) begin
                stat_q <= 1'b0;
            end
            irq <= |(stat_q & mask_q);
            wdt_reset <= uf_rst;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    property p_dec;
        @(posedge clk) disable iff (!nrst)
        running_q && tick && cnt_q != 15'h0000 && strap_done_q && !start_wr && !refresh
        |=> cnt_q == $past(cnt_q) - 15'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("counter did not decrement");
    property p_prot_src;
        @(posedge clk) disable iff (!nrst)
        pmc_q.prot |-> tick == lso_tick;
    endproperty
    a_prot_src: assert property (p_prot_src) else $error("wrong protected source");
    property p_stop;
        @(posedge clk) disable iff (!nrst)
        stop_mode && !pmc_q.prot |-> !tick;
    endproperty
    a_stop: assert property (p_stop) else $error("tick during stop");
    property p_refresh;
        @(posedge clk) disable iff (!nrst)
        refresh |=> cnt_q == $past(init_val);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh did not reload");
    property p_prot_rst;
        @(posedge clk) disable iff (!nrst)
        uflow && pmc_q.prot |=> wdt_reset && !$rose(stat_q[0]) ##1 !wdt_reset;
    endproperty
    a_prot_rst: assert property (p_prot_rst) else $error("protected underflow no reset");
    property p_init;
        @(posedge clk) disable iff (!nrst)
        use_sub && pmc_q.cvs == 2'h2 |-> init_val == 15'h07FF;
    endproperty
    a_init: assert property (p_init) else $error("wrong initial count");
    property p_rsv;
        @(posedge clk) disable iff (!nrst)
        psel && penable && !pready_q && !pwrite && paddr == `WDSP_OFF_PMC
        |=> prdata_q[6:3] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_sticky_prot;
        @(posedge clk) disable iff (!nrst)
        pmc_q.prot |=> pmc_q.prot;
    endproperty
    a_sticky_prot: assert property (p_sticky_prot) else $error("protect bit cleared");
    property p_irq;
        @(posedge clk) disable iff (!nrst)
        uf_irq && mask_q[0] |=> ##1 irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked underflow gave no interrupt");
    c_uflow: cover property (@(posedge clk) disable iff (!nrst) uf_irq);
    c_refresh: cover property (@(posedge clk) disable iff (!nrst) refresh);
    c_prot: cover property (@(posedge clk) disable iff (!nrst) $rose(pmc_q.prot));
endmodule

// [wdsp_tb_top.sv]
`timescale 1ns/100ps
`include "wdsp_regs.svh"
module wdsp_tb_top;
    // ****************************************
    // signals and instance
    // ****************************************
    logic clk = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, irq, wdt_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic subclock_input, lso_clk_in, stop_mode, wait_mode, underflow_reset_sel;
    logic auto_start_select, protect_after_reset_bit, sub_en;
    logic [1:0] sub_cnt;
    int mismatches = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (sub_en) begin
            sub_cnt <= sub_cnt + 2'h1;
            subclock_input <= sub_cnt[0];
        end
    end
    wdsp_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .subclock_input(subclock_input), .lso_clk_in(lso_clk_in),
        .stop_mode(stop_mode), .wait_mode(wait_mode),
        .underflow_reset_sel(underflow_reset_sel), .auto_start_select(auto_start_select),
        .protect_after_reset_bit(protect_after_reset_bit), .irq(irq), .wdt_reset(wdt_reset));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask
    task automatic cnt(output logic [31:0] r);
        logic e;
        apb(1'b0, `WDSP_OFF_START, 32'h0, r, e);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd("pmc reset", `WDSP_OFF_PMC, 32'h00);
        apb(1'b0, 12'h00C, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        wr(`WDSP_OFF_PMC, 32'h7F);
        rd("pmc unused bits", `WDSP_OFF_PMC, 32'h07);
        $display("test regs done");
    endtask
    task automatic t_init;
        logic [14:0] tbl [4] = '{15'h01FF, 15'h03FF, 15'h07FF, 15'h0FFF};
        stop_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`WDSP_OFF_PMC, 32'h4 | i);
            wr(`WDSP_OFF_START, 32'h0);
            rd("sub init", `WDSP_OFF_START, {17'h0, tbl[i]});
        end
        wr(`WDSP_OFF_PMC, 32'h3);
        wr(`WDSP_OFF_START, 32'h0);
        rd("cpu init", `WDSP_OFF_START, 32'h7FFF);
        $display("test init done");
    endtask
    task automatic t_refresh;
        logic [31:0] c;
        stop_mode <= 1'b0;
        repeat (200) @(posedge clk);
        stop_mode <= 1'b1;
        cnt(c);
        chk("cpu counts", 32'h1, {31'h0, c < 32'h7FFF});
        wr(`WDSP_OFF_REFRESH, 32'h55);
        wr(`WDSP_OFF_REFRESH, 32'hFF);
        rd("bad refresh", `WDSP_OFF_START, c);
        wr(`WDSP_OFF_REFRESH, 32'h00);
        wr(`WDSP_OFF_REFRESH, 32'hFF);
        rd("refresh", `WDSP_OFF_START, 32'h7FFF);
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        repeat (100) @(posedge clk);
        rd("wait halt", `WDSP_OFF_START, 32'h7FFF);
        wait_mode <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            wr(`WDSP_OFF_CTRL, b << `WDSP_CTRL_PRE_BIT);
            wr(`WDSP_OFF_START, 32'h0);
            repeat (320) @(posedge clk);
            cnt(c);
            c = 32'h7FFF - c;
            chk("prescale", 32'h1, b ? (c >= 1 && c <= 4) : (c >= 19 && c <= 22));
        end
        $display("test refresh done");
    endtask
    task automatic t_irq;
        int i;
        int nres = 0;
        wr(`WDSP_OFF_PMC, 32'h4);
        wr(`WDSP_OFF_MASK, 32'h1);
        wr(`WDSP_OFF_START, 32'h0);
        wait_mode <= 1'b1;
        sub_en <= 1'b1;
        for (i = 0; i < 40000; i++) begin
            @(posedge clk);
            if (wdt_reset === 1'b1) nres++;
            if (irq === 1'b1) break;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
        if (irq !== 1'b1) begin
            give_verdict();
        end
        chk("no reset", 32'h0, nres);
        rd("status", `WDSP_OFF_STAT, 32'h1);
        wr(`WDSP_OFF_MASK, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`WDSP_OFF_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`WDSP_OFF_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        underflow_reset_sel <= 1'b1;
        wr(`WDSP_OFF_START, 32'h0);
        for (i = 0; i < 40000; i++) begin
            @(posedge clk);
            if (wdt_reset === 1'b1) break;
        end
        chk("reset raised", 32'h1, {31'h0, wdt_reset});
        if (wdt_reset !== 1'b1) begin
            give_verdict();
        end
        @(posedge clk);
        chk("reset pulse", 32'h0, {31'h0, wdt_reset});
        chk("irq quiet", 32'h0, {31'h0, irq});
        rd("status quiet", `WDSP_OFF_STAT, 32'h0);
        underflow_reset_sel <= 1'b0;
        sub_en <= 1'b0;
        wait_mode <= 1'b0;
        $display("test irq done");
    endtask
    task automatic t_prot;
        logic [31:0] c0, c1;
        @(posedge clk);
        nrst <= 1'b0;
        auto_start_select <= 1'b0;
        protect_after_reset_bit <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd("pmc prot reset", `WDSP_OFF_PMC, 32'h80);
        wr(`WDSP_OFF_PMC, 32'h00);
        rd("prot sticky", `WDSP_OFF_PMC, 32'h80);
        wr(`WDSP_OFF_PMC, 32'h86);
        rd("source select locked", `WDSP_OFF_PMC, 32'h82);
        stop_mode <= 1'b1;
        cnt(c0);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            lso_clk_in <= 1'b1;
            repeat (4) @(posedge clk);
            lso_clk_in <= 1'b0;
            repeat (4) @(posedge clk);
        end
        cnt(c1);
        chk("lso ticks", c0 - 32'h6, c1);
        $display("test prot done");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        subclock_input = 1'b0;
        lso_clk_in = 1'b0;
        stop_mode = 1'b0;
        wait_mode = 1'b0;
        underflow_reset_sel = 1'b0;
        auto_start_select = 1'b1;
        protect_after_reset_bit = 1'b1;
        sub_en = 1'b0;
        sub_cnt = 2'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_init();
        t_refresh();
        t_irq();
        t_prot();
        give_verdict();
    end
endmodule
